// ### hw/frd_top.sv
// Behaviour
// - Class 0 warns only, motion continues.
// - Class 1 quick stop, amplifier stays on.
// - Class 2 quick stop, then switch off.
// - Class 3 switches off immediately.
// - Class 4 switches off, latched till power-off.
// - Limit switch quick stops, logged everywhere.
// - Class 1 error quick stops, logged everywhere.
// - Class above 1 faults, logged everywhere.
// - Report fixed power removal input source.
// - Keep last stop cause, ten-entry history.
`default_nettype none
module frd_top (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire frd_pkg::frd_event_type err_evt_i,
	input  wire logic                  sw_stop_i,
	input  wire logic                  positive_limit_switch,
	input  wire logic                  negative_limit_switch_i,
	input  wire logic                  power_removal_input_a,
	input  wire logic                  power_removal_input_b,
	input  wire logic                  standstill_i,
	input  wire logic                  fault_reset_i,
	output frd_pkg::frd_resp_type      resp_o,
	output frd_pkg::frd_state_type     state_o,
	output logic [frd_pkg::CODE_W-1:0] last_stop_cause_o,
	output logic [frd_pkg::HIST_DEPTH-1:0][frd_pkg::CODE_W-1:0] hist_o,
	output logic                       pwr_removed_a_o,
	output logic                       pwr_removed_b_o
);
	logic [2:0] sync_pos;
	logic [2:0] sync_neg;
	logic [1:0] sync_pa;
	logic [1:0] sync_pb;
	logic [1:0] sync_stand;
	logic       pos_d;
	logic       neg_d;
	logic       pos_rise;
	logic       neg_rise;

	// Limit pins: two-stage sync, third stage for edge detection
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_pos <= '0;
			sync_neg <= '0;
		end else begin
			sync_pos <= {sync_pos[1:0], positive_limit_switch};
			sync_neg <= {sync_neg[1:0], negative_limit_switch_i};
		end
	end

	// Safety inputs start at healthy high level, no false report
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_pa <= '1;
			sync_pb <= '1;
		end else begin
			sync_pa <= {sync_pa[0], power_removal_input_a};
			sync_pb <= {sync_pb[0], power_removal_input_b};
		end
	end

	// Standstill from the power stage
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_stand <= '0;
		end else begin
			sync_stand <= {sync_stand[0], standstill_i};
		end
	end
	assign pos_d    = sync_pos[2];
	assign neg_d    = sync_neg[2];
	assign pos_rise = sync_pos[1] & ~pos_d;
	assign neg_rise = sync_neg[1] & ~neg_d;

	// Event sources: 0 error, 1 positive limit, 2 negative limit, 3 software stop
	frd_pkg::frd_event_type [frd_pkg::NUM_SRC-1:0] evt;
	logic [frd_pkg::NUM_SRC-1:0] push;
	always_comb begin
		evt[0]          = err_evt_i;
		evt[1].valid    = pos_rise;
		evt[1].severity = frd_pkg::CLASS_QSTOP;
		evt[1].code     = frd_pkg::CODE_LIMIT;
		evt[2].valid    = neg_rise;
		evt[2].severity = frd_pkg::CLASS_QSTOP;
		evt[2].code     = frd_pkg::CODE_LIMIT;
		evt[3].valid    = sw_stop_i;
		evt[3].severity = frd_pkg::CLASS_QSTOP;
		evt[3].code     = frd_pkg::CODE_SW_STOP;
		// Warnings are logged in the history too; software stop skips the history
		push[0] = err_evt_i.valid;
		push[1] = pos_rise;
		push[2] = neg_rise;
		push[3] = 1'b0;
	end

	// Most severe stopping event among the simultaneous ones
	logic       any_stop;
	logic [2:0] worst_sev;
	logic [frd_pkg::CODE_W-1:0] worst_code;
	always_comb begin
		any_stop   = 1'b0;
		worst_sev  = frd_pkg::CLASS_WARN;
		worst_code = frd_pkg::CODE_NONE;
		for (int s = 0; s < frd_pkg::NUM_SRC; s++) begin
			if (evt[s].valid && evt[s].severity != frd_pkg::CLASS_WARN &&
			    (!any_stop || evt[s].severity > worst_sev)) begin
				any_stop   = 1'b1;
				worst_sev  = evt[s].severity;
				worst_code = evt[s].code;
			end
		end
	end

	logic warn_evt;
	assign warn_evt = err_evt_i.valid && err_evt_i.severity == frd_pkg::CLASS_WARN;

	frd_pkg::frd_state_type state;
	frd_pkg::frd_state_type next_state;

	always_comb begin
		next_state = state;
		case (state)
			frd_pkg::FRD_LOCKED: begin
				next_state = frd_pkg::FRD_LOCKED;
			end
			frd_pkg::FRD_QSTOP_OFF: begin
				if (any_stop && worst_sev >= frd_pkg::CLASS_UNCTL) begin
					next_state = frd_pkg::FRD_LOCKED;
				end else if (any_stop && worst_sev == frd_pkg::CLASS_FATAL) begin
					next_state = frd_pkg::FRD_FAULT;
				end else if (sync_stand[1]) begin
					next_state = frd_pkg::FRD_FAULT;
				end
			end
			frd_pkg::FRD_RUN, frd_pkg::FRD_QSTOP, frd_pkg::FRD_FAULT: begin
				if (state != frd_pkg::FRD_RUN && fault_reset_i && !any_stop) begin
					next_state = frd_pkg::FRD_RUN;
				end
				if (any_stop) begin
					case (worst_sev)
						frd_pkg::CLASS_QSTOP: begin
							if (state == frd_pkg::FRD_RUN) begin
								next_state = frd_pkg::FRD_QSTOP;
							end
						end
						frd_pkg::CLASS_QOFF: begin
							if (state != frd_pkg::FRD_FAULT) begin
								next_state = frd_pkg::FRD_QSTOP_OFF;
							end
						end
						frd_pkg::CLASS_FATAL: begin
							next_state = frd_pkg::FRD_FAULT;
						end
						default: begin
							next_state = frd_pkg::FRD_LOCKED;
						end
					endcase
				end
			end
			default: begin
				next_state = frd_pkg::FRD_FAULT;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= frd_pkg::FRD_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Responses registered from the next state, warning registered from the class 0 warning event
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			resp_o  <= '0;
			state_o <= frd_pkg::FRD_RUN;
		end else begin
			state_o             <= next_state;
			resp_o.amp_enable   <= next_state == frd_pkg::FRD_RUN ||
			                       next_state == frd_pkg::FRD_QSTOP ||
			                       next_state == frd_pkg::FRD_QSTOP_OFF;
			resp_o.quick_stop   <= next_state == frd_pkg::FRD_QSTOP ||
			                       next_state == frd_pkg::FRD_QSTOP_OFF;
			resp_o.fault        <= next_state == frd_pkg::FRD_FAULT ||
			                       next_state == frd_pkg::FRD_LOCKED;
			resp_o.warning      <= warn_evt;
		end
	end

	// Last stop cause follows the most severe new stop event
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_stop_cause_o <= frd_pkg::CODE_NONE;
		end else if (any_stop) begin
			last_stop_cause_o <= worst_code;
		end
	end

	// Fixed input assignment, no configuration
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_removed_a_o <= 1'b0;
			pwr_removed_b_o <= 1'b0;
		end else begin
			pwr_removed_a_o <= ~sync_pa[1];
			pwr_removed_b_o <= ~sync_pb[1];
		end
	end

	frd_history u_hist (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.push_i     (push),
		.evt_i      (evt),
		.hist_o     (hist_o)
	);
endmodule : frd_top
`default_nettype wire

// ### hw/frd_pkg.sv
`default_nettype none
package frd_pkg;
	localparam int CODE_W       = 16;
	localparam int HIST_DEPTH   = 10;
	localparam int HIST_IDX_W   = 4;
	localparam int NUM_SRC      = 4;
	localparam int SRC_W        = 2;

	// Stop cause codes
	localparam logic [CODE_W-1:0] CODE_NONE     = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_SW_STOP  = 16'ha306;
	localparam logic [CODE_W-1:0] CODE_LIMIT    = 16'ha302;

	// Severity classes
	localparam logic [2:0] CLASS_WARN  = 3'h0;
	localparam logic [2:0] CLASS_QSTOP = 3'h1;
	localparam logic [2:0] CLASS_QOFF  = 3'h2;
	localparam logic [2:0] CLASS_FATAL = 3'h3;
	localparam logic [2:0] CLASS_UNCTL = 3'h4;

	typedef enum logic [4:0] {
		FRD_RUN      = 5'b00001,
		FRD_QSTOP    = 5'b00010,
		FRD_QSTOP_OFF = 5'b00100,
		FRD_FAULT    = 5'b01000,
		FRD_LOCKED   = 5'b10000
	} frd_state_type;

	typedef struct packed {
		logic              valid;
		logic [2:0]        severity;
		logic [CODE_W-1:0] code;
	} frd_event_type;

	typedef struct packed {
		logic amp_enable;
		logic quick_stop;
		logic fault;
		logic warning;
	} frd_resp_type;
endpackage : frd_pkg
`default_nettype wire

// ### hw/frd_history.sv
`default_nettype none
module frd_history (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	input  wire logic [frd_pkg::NUM_SRC-1:0] push_i,
	input  wire frd_pkg::frd_event_type [frd_pkg::NUM_SRC-1:0] evt_i,
	output logic [frd_pkg::HIST_DEPTH-1:0][frd_pkg::CODE_W-1:0] hist_o
);
	logic [frd_pkg::HIST_DEPTH-1:0][frd_pkg::CODE_W-1:0] next_hist;

	// Shift in each pushed event, lowest source first, newest at slot 0
	always_comb begin
		next_hist = hist_o;
		for (int s = 0; s < frd_pkg::NUM_SRC; s++) begin
			if (push_i[s]) begin
				for (int k = frd_pkg::HIST_DEPTH-1; k > 0; k--) begin
					next_hist[k] = next_hist[k-1];
				end
				next_hist[0] = evt_i[s].code;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist_o <= '0;
		end else begin
			hist_o <= next_hist;
		end
	end
endmodule : frd_history
`default_nettype wire

// ### bench/frd_asserts.sv
`default_nettype none
module frd_chk (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire frd_pkg::frd_event_type err_evt_i,
	input wire logic sw_stop_i,
	input wire logic positive_limit_switch,
	input wire logic power_removal_input_a,
	input wire logic power_removal_input_b,
	input wire frd_pkg::frd_resp_type resp_o,
	input wire frd_pkg::frd_state_type state_o,
	input wire logic [frd_pkg::CODE_W-1:0] last_stop_cause_o,
	input wire logic [frd_pkg::HIST_DEPTH-1:0][frd_pkg::CODE_W-1:0] hist_o,
	input wire logic pwr_removed_a_o,
	input wire logic pwr_removed_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	wire v = err_evt_i.valid && !sw_stop_i;
	wire [2:0] sv = err_evt_i.severity;
	wire run = state_o == frd_pkg::FRD_RUN;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_warn; v && sv == 3'h0 && run |=> run && resp_o.warning; endproperty
	a_warn: assert property (p_warn) else $error("warning stopped motion");
	property p_q1; v && sv == 3'h1 && run |=>
		state_o == frd_pkg::FRD_QSTOP && resp_o.amp_enable; endproperty
	a_q1: assert property (p_q1) else $error("class 1 response wrong");
	property p_q2; v && sv == 3'h2 && run |=>
		state_o == frd_pkg::FRD_QSTOP_OFF && resp_o.quick_stop; endproperty
	a_q2: assert property (p_q2) else $error("class 2 response wrong");
	property p_f3; v && sv == 3'h3 && run |=> state_o == frd_pkg::FRD_FAULT &&
		!resp_o.amp_enable && last_stop_cause_o == $past(err_evt_i.code) &&
		hist_o[0] == $past(err_evt_i.code); endproperty
	a_f3: assert property (p_f3) else $error("class 3 response wrong");
	property p_f4; v && sv == 3'h4 |=>
		state_o == frd_pkg::FRD_LOCKED && !resp_o.amp_enable; endproperty
	a_f4: assert property (p_f4) else $error("class 4 response wrong");
	property p_lock; state_o == frd_pkg::FRD_LOCKED |=> $stable(state_o); endproperty
	a_lock: assert property (p_lock) else $error("locked state left");
	property p_sw; sw_stop_i && run && !err_evt_i.valid |=> state_o == frd_pkg::FRD_QSTOP
		&& last_stop_cause_o == frd_pkg::CODE_SW_STOP && $stable(hist_o); endproperty
	a_sw: assert property (p_sw) else $error("software stop wrong");
	property p_pwr; (!power_removal_input_a && power_removal_input_b) [*4] |->
		pwr_removed_a_o && !pwr_removed_b_o; endproperty
	a_pwr: assert property (p_pwr) else $error("wrong input reported");
	property p_lim; $rose(positive_limit_switch) && run |-> ##[1:6]
		state_o == frd_pkg::FRD_QSTOP && last_stop_cause_o == frd_pkg::CODE_LIMIT; endproperty
	a_lim: assert property (p_lim) else $error("limit stop wrong");
	c_lock: cover property (state_o == frd_pkg::FRD_LOCKED);
	c_off: cover property (state_o == frd_pkg::FRD_QSTOP_OFF ##1 state_o == frd_pkg::FRD_FAULT);
	c_pwr: cover property (pwr_removed_b_o);
endmodule : frd_chk
bind frd_top frd_chk frd_chk_inst (.core_clk_i, .rst_i, .err_evt_i, .sw_stop_i,
	.positive_limit_switch, .power_removal_input_a, .power_removal_input_b, .resp_o,
	.state_o, .last_stop_cause_o, .hist_o, .pwr_removed_a_o, .pwr_removed_b_o);
`default_nettype wire

// ### bench/frd_plant.sv
`default_nettype none
module frd_plant (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire frd_pkg::frd_resp_type resp_i,
	output logic                       standstill_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt;
	// Motor decelerates only under a powered quick stop
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			cnt <= 3'h0;
		else if (!(resp_i.quick_stop && resp_i.amp_enable))
			cnt <= 3'h0;
		else if (cnt != 3'h5)
			cnt <= cnt + 3'h1;
	end
	assign standstill_o = cnt == 3'h5;
endmodule : frd_plant
`default_nettype wire

// ### bench/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, sw, lp, ln, pa, pb, fr, ss, qa, qb;
	frd_pkg::frd_event_type ev;
	frd_pkg::frd_resp_type rsp;
	frd_pkg::frd_state_type st;
	logic [frd_pkg::CODE_W-1:0] cause, h;
	logic [frd_pkg::HIST_DEPTH-1:0][frd_pkg::CODE_W-1:0] hist;
	int n_mismatch, checked;
	frd_top frd_top_inst (.core_clk_i(clk), .rst_i(rst), .err_evt_i(ev), .sw_stop_i(sw),
		.positive_limit_switch(lp), .negative_limit_switch_i(ln),
		.power_removal_input_a(pa), .power_removal_input_b(pb), .standstill_i(ss),
		.fault_reset_i(fr), .resp_o(rsp), .state_o(st), .last_stop_cause_o(cause),
		.hist_o(hist), .pwr_removed_a_o(qa), .pwr_removed_b_o(qb));
	frd_plant frd_plant_inst (.core_clk_i(clk), .rst_i(rst), .resp_i(rsp), .standstill_o(ss));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic evt(input logic [2:0] s, input logic [15:0] c);
		@(negedge clk);
		ev = '{1'b1, s, c};
		@(negedge clk);
		ev = '0;
	endtask : evt
	task automatic wst(input frd_pkg::frd_state_type s);
		repeat (30) if (st !== s) @(negedge clk);
		chk("state", {11'h0, s}, {11'h0, st});
		if (st !== s) close_out;
	endtask : wst
	task automatic clr;
		fr = 1'b1;
		@(negedge clk);
		fr = 1'b0;
		wst(frd_pkg::FRD_RUN);
	endtask : clr
	task automatic t_warn;
		evt(3'h0, 16'h0a01);
		chk("warning", 16'h1, {15'h0, rsp.warning});
		chk("state", {11'h0, frd_pkg::FRD_RUN}, {11'h0, st});
	endtask : t_warn
	task automatic t_stops;
		evt(3'h1, 16'ha320);
		wst(frd_pkg::FRD_QSTOP);
		chk("amp", 16'h1, {15'h0, rsp.amp_enable});
		chk("hist0", 16'ha320, hist[0]);
		chk("cause", 16'ha320, cause);
		clr();
		evt(3'h2, 16'h0b02);
		wst(frd_pkg::FRD_QSTOP_OFF);
		chk("qstop", 16'h1, {15'h0, rsp.quick_stop});
		chk("hist0", 16'h0b02, hist[0]);
		wst(frd_pkg::FRD_FAULT);
		chk("amp", 16'h0, {15'h0, rsp.amp_enable});
		clr();
		evt(3'h3, 16'h0c03);
		chk("amp", 16'h0, {15'h0, rsp.amp_enable});
		chk("cause", 16'h0c03, cause);
		chk("fault", 16'h1, {15'h0, rsp.fault});
		clr();
	endtask : t_stops
	task automatic t_sw_lim;
		h = hist[0];
		sw = 1'b1;
		@(negedge clk);
		sw = 1'b0;
		chk("cause", frd_pkg::CODE_SW_STOP, cause);
		chk("hist0", h, hist[0]);
		clr();
		lp = 1'b1;
		wst(frd_pkg::FRD_QSTOP);
		chk("hist0", frd_pkg::CODE_LIMIT, hist[0]);
		lp = 1'b0;
		clr();
		ln = 1'b1;
		wst(frd_pkg::FRD_QSTOP);
		chk("cause", frd_pkg::CODE_LIMIT, cause);
		ln = 1'b0;
		clr();
	endtask : t_sw_lim
	task automatic t_pwr_hist;
		pa = 1'b0;
		repeat (5) @(negedge clk);
		chk("pwr", 16'h2, {14'h0, qa, qb});
		pa = 1'b1;
		pb = 1'b0;
		repeat (5) @(negedge clk);
		chk("pwr", 16'h1, {14'h0, qa, qb});
		pb = 1'b1;
		for (int i = 1; i <= 11; i++)
			evt(3'h0, 16'(i));
		chk("hist9", 16'h2, hist[9]);
	endtask : t_pwr_hist
	task automatic t_multi;
		@(negedge clk);
		ev = '{1'b1, 3'h3, 16'h0e03};
		sw = 1'b1;
		@(negedge clk);
		ev = '0;
		sw = 1'b0;
		chk("state", {11'h0, frd_pkg::FRD_FAULT}, {11'h0, st});
		chk("cause", 16'h0e03, cause);
		chk("hist0", 16'h0e03, hist[0]);
		chk("hist1", 16'h000b, hist[1]);
		clr();
	endtask : t_multi
	task automatic t_lock;
		evt(3'h4, 16'h0d04);
		chk("amp", 16'h0, {15'h0, rsp.amp_enable});
		fr = 1'b1;
		@(negedge clk);
		fr = 1'b0;
		repeat (3) @(negedge clk);
		chk("state", {11'h0, frd_pkg::FRD_LOCKED}, {11'h0, st});
	endtask : t_lock
	initial begin
		{rst, sw, lp, ln, pa, pb, fr} = 7'h46;
		ev = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_warn();
		t_stops();
		t_sw_lim();
		t_pwr_hist();
		t_multi();
		t_lock();
		close_out();
	end
endmodule : testbench
`default_nettype wire
